//--- rtl/bdp_bulky_data_port.sv
`timescale 1ns/1ns
module bdp_bulky_data_port import bdp_pkg::*; #(
    parameter int BUF_BYTES  = 8192,
    parameter int QDEPTH     = 1024,
    parameter int CYCLE_CLKS = ISO_CYCLE_CLKS
) (
    // System.
    input  wire logic        clk_sys_in,
    input  wire logic        resetn_in,
    // Register port.
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [31:0] reg_rdata_out,
    // Input port.
    input  wire logic        input_port_clock_in,
    input  wire logic        input_port_enable_in,
    input  wire logic [7:0]  input_data_lines_in,
    output logic      [7:0]  input_data_lines_out,
    output logic             input_data_lines_oe_out,
    input  wire logic [2:0]  input_format_bus_in,
    output logic      [2:0]  input_format_bus_out,
    output logic             input_format_bus_oe_out,
    input  wire logic        frame_pulse_in_in,
    output logic             input_port_busy_out,
    // Output port.
    input  wire logic        output_port_clock_in,
    input  wire logic        output_port_enable_in,
    output logic      [7:0]  output_data_lines_out,
    output logic      [2:0]  output_format_bus_out,
    output logic             frame_pulse_out_out,
    output logic             output_data_available_out
);
    localparam int PW = $clog2(QDEPTH);
    localparam int CW = $clog2(QDEPTH + 1);

    function automatic logic [$clog2(BUF_BYTES)-1:0] qaddr(input logic [2:0] q, input logic [PW-1:0] p);
        qaddr = $clog2(BUF_BYTES)'(int'(q) * QDEPTH + int'(p));
    endfunction

    logic rst_m, rst_n;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_m <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_n <= rst_m;
        end
    end

    // Every pin from the partner passes two flip-flops; edges are found on the second stage.
    logic [15:0] pin_m, pin_s;
    logic        iclk_d, oclk_d;
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            pin_m  <= 16'h0;
            pin_s  <= 16'h0;
            iclk_d <= 1'b0;
            oclk_d <= 1'b0;
        end else begin
            pin_m  <= {frame_pulse_in_in, output_port_enable_in, output_port_clock_in,
                       input_port_enable_in, input_port_clock_in, input_format_bus_in, input_data_lines_in};
            pin_s  <= pin_m;
            iclk_d <= pin_s[11];
            oclk_d <= pin_s[13];
        end
    end
    logic [7:0] in_data;
    logic [2:0] in_fmt;
    logic       in_en, out_en, frame_in, in_edge, out_edge;
    assign in_data  = pin_s[7:0];
    assign in_fmt   = pin_s[10:8];
    assign in_en    = pin_s[12];
    assign out_en   = pin_s[14];
    assign frame_in = pin_s[15];
    assign in_edge  = pin_s[11] & ~iclk_d;
    assign out_edge = pin_s[13] & ~oclk_d;

    // Registers written by software.
    logic [CTRL_W-1:0] ctrl;
    logic [DBG_W-1:0]  dbg;
    logic [7:0]        retry_lim, retry_ivl, src_id;
    logic [15:0]       ts_tx_off, ts_rx_off, ts_rx_raw;
    logic              wr_ctrl;
    assign wr_ctrl = reg_wr_in;
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            ctrl      <= '0;
            dbg       <= '0;
            retry_lim <= 8'h0;
            retry_ivl <= 8'h0;
            src_id    <= 8'h0;
            ts_tx_off <= 16'h0;
            ts_rx_off <= 16'h0;
            ts_rx_raw <= 16'h0;
        end else if (wr_ctrl) begin
            unique case (reg_addr_in)
                ADDR_CTRL:      ctrl <= reg_wdata_in[CTRL_W-1:0];
                ADDR_DEBUG_SEL: dbg  <= reg_wdata_in[DBG_W-1:0];
                ADDR_RETRY:     {retry_ivl, retry_lim} <= reg_wdata_in[15:0];
                ADDR_SRC_ID:    src_id <= reg_wdata_in[7:0];
                ADDR_TS_TX_OFF: ts_tx_off <= reg_wdata_in[15:0];
                ADDR_TS_RX_OFF: ts_rx_off <= reg_wdata_in[15:0];
                ADDR_TS_RX:     ts_rx_raw <= reg_wdata_in[15:0];
                default: ;
            endcase
        end
    end
    logic       tx_mem, rx_mem;
    logic [1:0] rx_sel;
    assign tx_mem = ctrl[CTRL_TX_MEM];
    assign rx_mem = ctrl[CTRL_RX_MEM];
    assign rx_sel = ctrl[CTRL_RX_SEL_LO +: 2];

    // Six queues in one shared buffer, each a fixed slice of it.
    logic [8:0]    mem [BUF_BYTES];
    logic [PW-1:0] wp [NUM_Q];
    logic [PW-1:0] rp [NUM_Q];
    logic [CW-1:0] cnt [NUM_Q];
    logic [NUM_Q-1:0] push, pop, full, empty;
    always_comb begin
        for (int q = 0; q < NUM_Q; q++) begin
            full[q]  = cnt[q] == CW'(QDEPTH);
            empty[q] = cnt[q] == '0;
        end
    end

    logic       sw_q_hit;
    logic [2:0] sw_q;
    assign sw_q_hit = reg_addr_in >= ADDR_QDATA && reg_addr_in <= ADDR_QDATA_END && reg_addr_in[1:0] == 2'h0;
    assign sw_q     = 3'((reg_addr_in - ADDR_QDATA) >> 2);

    // Input port: format bits 1:0 pick the transmit queue, bit 2 marks a frame start.
    logic       port_push, sw_push;
    logic [2:0] port_q;
    assign port_q    = Q_TX_FIRST + {1'b0, in_fmt[1:0]};
    assign port_push = in_edge && in_en && !tx_mem && in_fmt[1:0] != FMT_BAD && !full[port_q];
    assign sw_push   = reg_wr_in && sw_q_hit && (sw_q < Q_TX_FIRST || tx_mem) && !full[sw_q];

    // Output port drains the selected receive queue in bytewide mode.
    logic port_pop, sw_pop, dv_pop;
    bdp_dv_e dv_st;
    assign port_pop = out_edge && out_en && !rx_mem && !empty[rx_sel];
    assign dv_pop   = dv_st == DV_PAYLOAD;
    assign sw_pop   = reg_rd_in && sw_q_hit && !empty[sw_q] && (sw_q != Q_TX_DV || dv_pop)
                      && (sw_q >= Q_TX_FIRST || rx_mem);

    always_comb begin
        for (int q = 0; q < NUM_Q; q++) begin
            push[q] = (port_push && port_q == 3'(q)) || (sw_push && sw_q == 3'(q));
            pop[q]  = (port_pop && {1'b0, rx_sel} == 3'(q)) || (sw_pop && sw_q == 3'(q));
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            for (int q = 0; q < NUM_Q; q++) begin
                wp[q]  <= '0;
                rp[q]  <= '0;
                cnt[q] <= '0;
            end
        end else begin
            for (int q = 0; q < NUM_Q; q++) begin
                if (push[q]) wp[q] <= wp[q] + 1'b1;
                if (pop[q])  rp[q] <= rp[q] + 1'b1;
                cnt[q] <= cnt[q] + CW'(push[q]) - CW'(pop[q]);
            end
        end
    end
    // Port and software writes never target the same queue in one cycle, so two write ports are safe.
    always_ff @(posedge clk_sys_in) begin
        if (port_push) mem[qaddr(port_q, wp[port_q])] <= {in_fmt[2], in_data};
        if (sw_push)   mem[qaddr(sw_q, wp[sw_q])] <= reg_wdata_in[8:0];
    end
    logic [8:0] port_head, sw_head;
    assign port_head = mem[qaddr({1'b0, rx_sel}, rp[rx_sel])];
    assign sw_head   = mem[qaddr(sw_q, rp[sw_q])];

    // Output port pins; the frame output toggles at each marked DV byte for an even duty cycle.
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            output_data_lines_out <= 8'h0;
            output_format_bus_out <= 3'h0;
            frame_pulse_out_out   <= 1'b0;
        end else begin
            if (port_pop) begin
                output_data_lines_out <= port_head[7:0];
                output_format_bus_out <= {port_head[QD_MARK], rx_sel};
            end
            if ((port_pop && {1'b0, rx_sel} == Q_RX_DV && port_head[QD_MARK]) ||
                (sw_pop && sw_q == Q_RX_DV && sw_head[QD_MARK]))
                frame_pulse_out_out <= ~frame_pulse_out_out;
        end
    end

    // Input port turns around only when asked and not strapped input-only.
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            input_data_lines_out    <= 8'h0;
            input_data_lines_oe_out <= 1'b0;
            input_format_bus_out    <= 3'h0;
            input_format_bus_oe_out <= 1'b0;
        end else begin
            input_data_lines_out    <= output_data_lines_out;
            input_format_bus_out    <= output_format_bus_out;
            input_data_lines_oe_out <= ctrl[CTRL_IN_DRIVE] && !ctrl[CTRL_IN_ONLY] && !in_en;
            input_format_bus_oe_out <= ctrl[CTRL_IN_DRIVE] && !ctrl[CTRL_IN_ONLY] && !in_en;
        end
    end

    // Isochronous cycle timer and cycle count.
    logic [$clog2(CYCLE_CLKS)-1:0] cyc_div;
    logic [15:0] cyc_cnt;
    logic        tick;
    assign tick = cyc_div == ($clog2(CYCLE_CLKS))'(CYCLE_CLKS - 1);
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            cyc_div <= '0;
            cyc_cnt <= 16'h0;
        end else begin
            cyc_div <= tick ? '0 : cyc_div + 1'b1;
            if (tick) cyc_cnt <= cyc_cnt + 16'h1;
        end
    end

    // DV transmit read shaping: header, optional header DIF block, payload or empty packet.
    logic [9:0] dv_idx;
    logic       dv_full;
    logic [7:0] dbc;
    logic [15:0] empty_cnt;
    logic       dv_rd;
    assign dv_rd = reg_rd_in && sw_q_hit && sw_q == Q_TX_DV;
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            dv_st     <= DV_IDLE;
            dv_idx    <= 10'h0;
            dv_full   <= 1'b0;
            dbc       <= 8'h0;
            empty_cnt <= 16'h0;
        end else begin
            unique case (dv_st)
                DV_IDLE: if (tick) begin
                    dv_st   <= DV_CIP;
                    dv_idx  <= 10'h0;
                    dv_full <= cnt[Q_TX_DV] >= CW'(DV_PKT_BYTES);
                    if (cnt[Q_TX_DV] < CW'(DV_PKT_BYTES)) empty_cnt <= empty_cnt + 16'h1;
                end
                DV_CIP: if (dv_rd) begin
                    dv_idx <= dv_idx + 10'h1;
                    if (dv_idx == 10'(CIP_BYTES - 1)) begin
                        dv_idx <= 10'h0;
                        if (!dv_full) dv_st <= DV_IDLE;
                        else if (sw_head[QD_MARK]) dv_st <= DV_DIF;
                        else dv_st <= DV_PAYLOAD;
                        if (dv_full) dbc <= dbc + 8'h1;
                    end
                end
                DV_DIF: if (dv_rd) begin
                    dv_idx <= dv_idx + 10'h1;
                    if (dv_idx == 10'(DIF_BYTES - 1)) begin
                        dv_idx <= 10'h0;
                        dv_st  <= DV_PAYLOAD;
                    end
                end
                DV_PAYLOAD: if (dv_rd) begin
                    dv_idx <= dv_idx + 10'h1;
                    if (dv_idx == 10'(DV_PKT_BYTES - 1) || empty[Q_TX_DV]) dv_st <= DV_IDLE;
                end
            endcase
        end
    end

    // Async transmit retry: up to retry_lim+1 retries, each after retry_ivl+1 isochronous cycle ticks.
    logic       rt_active, rt_pending, rt_give_up;
    logic [7:0] rt_left;
    logic [8:0] rt_wait;
    logic       cmd_wr;
    assign cmd_wr = reg_wr_in && reg_addr_in == ADDR_RETRY_CMD;
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            rt_active  <= 1'b0;
            rt_pending <= 1'b0;
            rt_give_up <= 1'b0;
            rt_left    <= 8'h0;
            rt_wait    <= 9'h0;
        end else begin
            if (cmd_wr && reg_wdata_in[RETRY_CMD_CLEAR]) begin
                rt_pending <= 1'b0;
                rt_give_up <= 1'b0;
            end
            if (tick && rt_active && rt_wait != 9'h0) begin
                rt_wait <= rt_wait - 9'h1;
                if (rt_wait == 9'h1) rt_pending <= 1'b1;
            end
            if (cmd_wr && reg_wdata_in[RETRY_CMD_OK]) rt_active <= 1'b0;
            else if (cmd_wr && reg_wdata_in[RETRY_CMD_FAIL]) begin
                if (rt_active && rt_left == 8'h0) begin
                    rt_active  <= 1'b0;
                    rt_give_up <= 1'b1;
                end else begin
                    rt_active <= 1'b1;
                    rt_left   <= rt_active ? rt_left - 8'h1 : retry_lim;
                    rt_wait   <= {1'b0, retry_ivl} + 9'h1;
                end
            end
        end
    end

    // Pins with a status alternative, all from flip-flops.
    logic [7:0] dbg_src;
    assign dbg_src = {rt_give_up, rt_pending, rt_active, tick, frame_in, in_en, out_en, dv_full};
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            input_port_busy_out       <= 1'b1;
            output_data_available_out <= 1'b0;
        end else begin
            input_port_busy_out <= dbg[DBG_STATUS_LINE_THREE] ? dbg_src[dbg[DBG_SRC_LO +: 3]]
                                   : (tx_mem || (|full[5:3]));
            output_data_available_out <= dbg[DBG_STATUS_LINE_TWO] ? dbg_src[dbg[DBG_SRC_LO +: 3]]
                                         : (!rx_mem && !empty[rx_sel]);
        end
    end

    // Read data stands in the cycle after the read strobe only.
    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h0;
        if (sw_q_hit) begin
            if (sw_q == Q_TX_DV) begin
                unique case (dv_st)
                    DV_CIP:     rd_val = {24'h0, dv_idx == 10'h0 ? src_id : dbc};
                    DV_DIF:     rd_val = {24'h0, DIF_HDR_ID};
                    DV_PAYLOAD: rd_val = {23'h0, sw_head};
                    DV_IDLE:    rd_val = 32'h0;
                endcase
            end else if (sw_pop) rd_val = {23'h0, sw_head};
        end else begin
            unique case (reg_addr_in)
                ADDR_CTRL:      rd_val = {26'h0, ctrl};
                ADDR_STATUS:    rd_val = {empty_cnt, 1'b0, rt_give_up, rt_pending, rt_active, full, empty};
                ADDR_RETRY:     rd_val = {16'h0, retry_ivl, retry_lim};
                ADDR_RETRY_CMD: rd_val = {15'h0, rt_wait, rt_left};
                ADDR_TS_TX_OFF: rd_val = {16'h0, ts_tx_off};
                ADDR_TS_RX_OFF: rd_val = {16'h0, ts_rx_off};
                ADDR_TS_TX:     rd_val = {16'h0, cyc_cnt + ts_tx_off};
                ADDR_TS_RX:     rd_val = {16'h0, ts_rx_raw + ts_rx_off};
                ADDR_DEBUG_SEL: rd_val = {25'h0, dbg};
                ADDR_SRC_ID:    rd_val = {24'h0, src_id};
                default:        rd_val = 32'h0;
            endcase
        end
    end
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n)         reg_rdata_out <= 32'h0;
        else if (reg_rd_in) reg_rdata_out <= rd_val;
        else                reg_rdata_out <= 32'h0;
    end

endmodule

//--- rtl/bdp_pkg.sv
package bdp_pkg;

    // Queue numbering: receive queues first, then transmit queues.
    localparam int          NUM_Q      = 6;
    localparam logic [2:0]  Q_RX_DV    = 3'h0;
    localparam logic [2:0]  Q_TX_DV    = 3'h3;
    localparam logic [2:0]  Q_TX_FIRST = 3'h3;
    localparam logic [1:0]  FMT_BAD    = 2'h3;

    // Register byte addresses.
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_STATUS   = 8'h04;
    localparam logic [7:0]  ADDR_RETRY    = 8'h18;
    localparam logic [7:0]  ADDR_RETRY_CMD = 8'h1c;
    localparam logic [7:0]  ADDR_TS_TX_OFF = 8'h20;
    localparam logic [7:0]  ADDR_TS_RX_OFF = 8'h24;
    localparam logic [7:0]  ADDR_TS_TX     = 8'h28;
    localparam logic [7:0]  ADDR_TS_RX     = 8'h2c;
    localparam logic [7:0]  ADDR_DEBUG_SEL = 8'h30;
    localparam logic [7:0]  ADDR_SRC_ID    = 8'h34;
    localparam logic [7:0]  ADDR_QDATA     = 8'h40;
    localparam logic [7:0]  ADDR_QDATA_END = 8'h54;

    // Control register fields.
    localparam int CTRL_TX_MEM    = 0;
    localparam int CTRL_RX_MEM    = 1;
    localparam int CTRL_IN_ONLY   = 2;
    localparam int CTRL_IN_DRIVE  = 3;
    localparam int CTRL_RX_SEL_LO = 4;
    localparam int CTRL_W         = 6;

    // Debug select fields.
    localparam int DBG_STATUS_LINE_TWO   = 0;
    localparam int DBG_STATUS_LINE_THREE   = 1;
    localparam int DBG_SRC_LO  = 4;
    localparam int DBG_W       = 7;

    // Queue data word: byte plus frame-start mark.
    localparam int QD_MARK     = 8;
    localparam int RETRY_CMD_FAIL  = 0;
    localparam int RETRY_CMD_OK    = 1;
    localparam int RETRY_CMD_CLEAR = 2;

    // DV packet shaping.
    localparam int         DV_PKT_BYTES = 480;
    localparam int         CIP_BYTES    = 8;
    localparam int         DIF_BYTES    = 80;
    localparam logic [7:0] DIF_HDR_ID   = 8'h1f;

    // Timing.
    localparam int CLK_NS       = 8;
    localparam int ISO_CYCLE_NS = 125000;
    localparam int ISO_CYCLE_CLKS = ISO_CYCLE_NS / CLK_NS;

    typedef enum logic [1:0] {DV_IDLE, DV_CIP, DV_DIF, DV_PAYLOAD} bdp_dv_e;

endpackage

//--- testbench/bdp_av_model.sv
`timescale 1ns/1ns
module bdp_av_model (
    // Pacing clock.
    input  wire logic       clk_sys_in,
    // Pins toward the device.
    output logic            in_clk_out,
    output logic            in_en_out,
    output logic      [7:0] in_data_out,
    output logic      [2:0] in_fmt_out,
    output logic            frame_out,
    output logic            out_clk_out,
    output logic            out_en_out
);
    initial begin
        {in_clk_out, in_en_out, in_data_out, in_fmt_out} = '0;
        {frame_out, out_clk_out, out_en_out} = '0;
    end
    // Frame pulse scaled down at 50 percent duty; a true frame rate would make the run far too long.
    always begin
        repeat (1000) @(posedge clk_sys_in);
        frame_out <= ~frame_out;
    end
    // One 80 ns port clock period; the clock stands still between transfers.
    task automatic beat(input bit inp);
        repeat (5) @(posedge clk_sys_in);
        if (inp) in_clk_out <= 1'b1;
        else out_clk_out <= 1'b1;
        repeat (5) @(posedge clk_sys_in);
        in_clk_out  <= 1'b0;
        out_clk_out <= 1'b0;
    endtask
    task automatic send(input logic [7:0] d, input logic [2:0] f, input logic en);
        @(posedge clk_sys_in);
        in_data_out <= d;
        in_fmt_out  <= f;
        in_en_out   <= en;
        beat(1'b1);
        // Released lines show the inverse, so a late sample cannot pass by luck.
        in_data_out <= ~d;
        in_fmt_out  <= ~f;
        in_en_out   <= 1'b0;
    endtask
    task automatic pull(input logic en);
        @(posedge clk_sys_in);
        out_en_out <= en;
        beat(1'b0);
        out_en_out <= 1'b0;
    endtask
endmodule

//--- testbench/bdp_bulky_data_port_tb.sv
`timescale 1ns/1ns
module bdp_bulky_data_port_tb import bdp_pkg::*; ();
    logic        clk_sys = 1'b0;
    logic        resetn  = 1'b0;
    logic [7:0]  addr    = '0;
    logic [31:0] wdata   = '0;
    logic        wr_s    = 1'b0;
    logic        rd_s    = 1'b0;
    logic [31:0] rdata, q;
    logic        iclk, ien, ifr, oclk, oen, oe_d, oe_f, busy, avail, fro;
    logic [7:0]  m_d, d_o, odata;
    logic [2:0]  m_f, f_o, ofmt;
    logic [8:0]  w [5];
    int          num_errors = 0;
    int          checked    = 0;

    always #4 clk_sys = ~clk_sys;

    bdp_av_model u_av (.clk_sys_in(clk_sys), .in_clk_out(iclk), .in_en_out(ien), .in_data_out(m_d),
        .in_fmt_out(m_f), .frame_out(ifr), .out_clk_out(oclk), .out_en_out(oen));

    bdp_bulky_data_port #(.CYCLE_CLKS(20)) u_dut (.clk_sys_in(clk_sys), .resetn_in(resetn),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
        .input_port_clock_in(iclk), .input_port_enable_in(ien), .input_data_lines_in(oe_d ? d_o : m_d),
        .input_data_lines_out(d_o), .input_data_lines_oe_out(oe_d), .input_format_bus_in(oe_f ? f_o : m_f),
        .input_format_bus_out(f_o), .input_format_bus_oe_out(oe_f), .frame_pulse_in_in(ifr),
        .input_port_busy_out(busy), .output_port_clock_in(oclk), .output_port_enable_in(oen),
        .output_data_lines_out(odata), .output_format_bus_out(ofmt), .frame_pulse_out_out(fro),
        .output_data_available_out(avail));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge clk_sys);
        wr_s <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_sys);
        rd_s <= 1'b0;
        #1 q = rdata;
        @(posedge clk_sys);
    endtask
    function automatic logic [7:0] qaddr(input int n);
        return ADDR_QDATA + 8'(4 * n);
    endfunction
    function automatic logic [15:0] ts_sum(input logic [15:0] raw, input logic [15:0] off);
        return raw + off;
    endfunction
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // The tests need some 2200 cycles; the limit leaves ample room.
    initial begin
        #100000;
        num_errors++;
        conclude();
    end

    initial begin
        logic [7:0]  b;
        logic        f;
        logic [15:0] raw, off;
        void'($urandom(32'hf6f4));
        repeat (12) @(posedge clk_sys);
        chk(32'(busy), 32'h1, "busy in reset");
        resetn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(ADDR_STATUS);
        chk(32'(q[11:0]), 32'h3f, "six queues empty");
        rd(8'h08);
        chk(q, 32'h0, "unmapped read");
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            w[i] = 9'($urandom);
            u_av.send(w[i][7:0], {w[i][8], 2'h1}, 1'b1);
        end
        w[4] = '0;
        u_av.send(8'h5a, 3'h1, 1'b0);
        u_av.send(8'ha5, 3'h3, 1'b1);
        wr(ADDR_CTRL, 32'h1);
        @(posedge clk_sys);
        chk(32'(busy), 32'h1, "busy in tx memory mode");
        for (int i = 0; i < 5; i++) begin
            rd(qaddr(4));
            chk(q, 32'(w[i]), "tx iso word");
        end
        $display("input port test done");
        wr(ADDR_CTRL, 32'h2);
        for (int i = 0; i < 3; i++) begin
            w[i] = {i != 1, 8'($urandom)};
            wr(qaddr(0), 32'(w[i]));
        end
        wr(ADDR_CTRL, 32'h0);
        rd(qaddr(0));
        chk(q, 32'h0, "rx queue closed to software");
        repeat (3) @(posedge clk_sys);
        chk(32'(avail), 32'h1, "output available");
        b = odata;
        f = fro;
        u_av.pull(1'b0);
        chk(32'(odata), 32'(b), "lines hold while disabled");
        for (int i = 0; i < 3; i++) begin
            u_av.pull(1'b1);
            f ^= w[i][8];
            chk(32'({ofmt, odata}), 32'({w[i][8], 2'h0, w[i][7:0]}), "popped byte");
            chk(32'(fro), 32'(f), "frame pulse out");
        end
        repeat (3) @(posedge clk_sys);
        chk(32'(avail), 32'h0, "queue drained");
        $display("output port test done");
        wr(ADDR_DEBUG_SEL, 32'h33);
        repeat (2) begin
            @(ifr);
            repeat (8) @(posedge clk_sys);
            chk(32'({busy, avail}), 32'({ifr, ifr}), "status pins follow frame");
        end
        wr(ADDR_DEBUG_SEL, 32'h0);
        $display("debug select test done");
        wr(ADDR_CTRL, 32'h8);
        repeat (6) @(posedge clk_sys);
        chk(32'(oe_d), 32'h1, "input lines driven");
        chk(32'(d_o), 32'(odata), "input lines echo");
        wr(ADDR_CTRL, 32'hc);
        repeat (3) @(posedge clk_sys);
        chk(32'({oe_f, oe_d}), 32'h0, "input only");
        wr(ADDR_CTRL, 32'h0);
        $display("line direction test done");
        raw = 16'($urandom);
        off = 16'($urandom);
        wr(ADDR_TS_RX_OFF, 32'(off));
        wr(ADDR_TS_RX, 32'(raw));
        rd(ADDR_TS_RX);
        chk(32'(q[15:0]), 32'(ts_sum(raw, off)), "rx timestamp");
        wr(ADDR_RETRY, 32'h100);
        wr(ADDR_RETRY_CMD, 32'h1);
        repeat (60) @(posedge clk_sys);
        rd(ADDR_STATUS);
        chk(32'(q[14:12]), 32'h3, "retry pending");
        wr(ADDR_RETRY_CMD, 32'h1);
        rd(ADDR_STATUS);
        chk(32'(q[14:12]), 32'h6, "retry give up");
        rd(ADDR_STATUS);
        raw = q[31:16];
        b = 8'($urandom);
        wr(ADDR_SRC_ID, 32'(b));
        for (int i = 0; i < 8; i++) begin
            rd(qaddr(3));
            chk(q, i == 0 ? 32'(b) : 32'h0, "cip header byte");
        end
        repeat (30) @(posedge clk_sys);
        rd(ADDR_STATUS);
        chk(32'(q[31:16]), 32'(raw + 16'h1), "one empty packet");
        chk(32'(busy), 32'h0, "not busy");
        $display("timestamp and packet test done");
        conclude();
    end
endmodule

//--- testbench/bdp_chk_sva.sv
`timescale 1ns/1ns
module bdp_chk_sva import bdp_pkg::*; (
    // Clock, reset and register writes.
    input wire logic        clk_sys_in,
    input wire logic        resetn_in,
    input wire logic [7:0]  reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic        reg_wr_in,
    // Port pins.
    input wire logic        frame_pulse_in_in,
    input wire logic        input_port_enable_in,
    input wire logic        input_data_lines_oe_out,
    input wire logic        input_format_bus_oe_out,
    input wire logic        output_port_enable_in,
    input wire logic [7:0]  output_data_lines_out,
    input wire logic [2:0]  output_format_bus_out,
    input wire logic        frame_pulse_out_out,
    input wire logic        input_port_busy_out,
    input wire logic        output_data_available_out
);
    logic [5:0] ctrl;
    logic [6:0] dbg;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl <= '0;
            dbg  <= '0;
        end else if (reg_wr_in && reg_addr_in == ADDR_CTRL) begin
            ctrl <= reg_wdata_in[5:0];
        end else if (reg_wr_in && reg_addr_in == ADDR_DEBUG_SEL) begin
            dbg <= reg_wdata_in[6:0];
        end
    end
    // Source 3 routes the synced frame input, so the pin lags it by the synchroniser.
    wire s3 = dbg[DBG_STATUS_LINE_THREE] && dbg[6:4] == 3'h3;
    wire s2 = dbg[DBG_STATUS_LINE_TWO] && dbg[6:4] == 3'h3;
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!resetn_in);
    rst_vals_a: assert property (disable iff (1'b0) !resetn_in[*2] |-> input_port_busy_out && !output_data_available_out)
        else $error("status pins wrong in reset");
    busy_txmem_a: assert property ((ctrl[CTRL_TX_MEM] && !dbg[DBG_STATUS_LINE_THREE])[*2] |-> input_port_busy_out)
        else $error("busy low in tx memory mode");
    avail_rxmem_a: assert property ((ctrl[CTRL_RX_MEM] && !dbg[DBG_STATUS_LINE_TWO])[*2] |-> !output_data_available_out)
        else $error("available high in rx memory mode");
    status_line_three_src_a: assert property ((s3 && $stable(frame_pulse_in_in))[*6] |-> input_port_busy_out == frame_pulse_in_in)
        else $error("status three not following source");
    status_line_two_src_a: assert property ((s2 && $stable(frame_pulse_in_in))[*6] |-> output_data_available_out == frame_pulse_in_in)
        else $error("status two not following source");
    out_hold_a: assert property (!output_port_enable_in[*8] |=> $stable(output_data_lines_out) &&
        $stable(output_format_bus_out) && $stable(frame_pulse_out_out)) else $error("output moved while disabled");
    frame_mark_a: assert property ($changed(frame_pulse_out_out) |-> output_format_bus_out == 3'h4)
        else $error("frame pulse without marked dv byte");
    in_drive_a: assert property ((ctrl[CTRL_IN_DRIVE] && !ctrl[CTRL_IN_ONLY] && !input_port_enable_in)[*6]
        |-> input_data_lines_oe_out) else $error("input lines not driven");
    in_only_a: assert property (ctrl[CTRL_IN_ONLY][*3] |-> !input_data_lines_oe_out && !input_format_bus_oe_out)
        else $error("input only lines driven");
    cover property ($changed(frame_pulse_out_out));
    cover property (input_data_lines_oe_out);
    cover property ($rose(output_data_available_out));
endmodule

bind bdp_bulky_data_port bdp_chk_sva u_sva (.clk_sys_in, .resetn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .frame_pulse_in_in, .input_port_enable_in, .input_data_lines_oe_out, .input_format_bus_oe_out,
    .output_port_enable_in, .output_data_lines_out, .output_format_bus_out, .frame_pulse_out_out,
    .input_port_busy_out, .output_data_available_out);
